// File: ctx_pkg.sv
// Purpose: Shared constants for the interrupt context unit and flag register.
// Assumes: APB slave with 32-bit data and 12-bit byte addresses.
// Notes: Shadow registers sit in the window of data bank 31.
package ctx_pkg;
  // Register file geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int UNITS = 5;
  localparam int EVT_W = 3;
  localparam logic [4:0] SHADOW_BANK = 5'h1F;
  // Each bank occupies 16 words of APB space; bank 31 starts at 0x7C0.
  localparam logic [ADDR_W-1:0] SHADOW_BASE = 12'h7C0;
  // Control and status registers.
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATE = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h010;
  // Shadow registers, at their full APB addresses inside the bank 31 window.
  localparam logic [ADDR_W-1:0] OFS_SH_ACC = 12'h7C0;
  localparam logic [ADDR_W-1:0] OFS_SH_STATUS = 12'h7C4;
  localparam logic [ADDR_W-1:0] OFS_SH_BANK = 12'h7C8;
  localparam logic [ADDR_W-1:0] OFS_SH_PTR0 = 12'h7CC;
  localparam logic [ADDR_W-1:0] OFS_SH_PTR1 = 12'h7D0;
  localparam logic [ADDR_W-1:0] OFS_SH_PCH = 12'h7D4;
  // Core register widths.
  localparam int PC_W = 15;
  localparam int PCH_W = 7;
  localparam int BSEL_W = 6;
  localparam int PTR_W = 16;
  // Core status bits that are never saved or restored.
  localparam int WDOG_EXPIRY_BIT = 4;
  localparam int SLEEP_ENTERED_BIT = 3;
  localparam logic [7:0] STATUS_EXCL = 8'h18;
  // Enable register fields.
  localparam int EN_GLOBAL_BIT = 7;
  // Interrupt status event bits.
  localparam int EV_ENTRY = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_OVERWRITE = 2;
  // Reset values.
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] SHADOW_RST = 8'h00;
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_VECTOR, ST_ISR} seq_t;
endpackage

// File: ccp_flag_reg.sv
// Purpose: Sticky event flags of the five capture/compare/PWM units.
// Assumes: Unit events are one-cycle pulses on pclk.
// Notes: A hardware event wins over a software write in the same cycle.
`timescale 1ns/100ps
module ccp_flag_reg #(
  parameter int N = ctx_pkg::UNITS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Unit events, already qualified by each unit's mode.
  input wire logic [N-1:0] unit_event,
  // Software write port.
  input wire logic wr_en,
  input wire logic [N-1:0] wr_data,
  // Flag contents.
  output logic [N-1:0] flags
);
  typedef struct packed {
    logic [N-1:0] flag;
  } fstate_t;

  fstate_t s_r, s_nxt;
  logic [N-1:0] cell_nxt;

  // One cell per unit: set on event regardless of enables, else take a write, else hold.
  generate
    for (genvar i = 0; i < N; i++)
    begin : g_cell
      always_comb
      begin
        if (unit_event[i])
          cell_nxt[i] = 1'b1;
        else if (wr_en)
          cell_nxt[i] = wr_data[i];
        else
          cell_nxt[i] = s_r.flag[i];
      end
    end
  endgenerate

  // The whole next state is filled in one place from the cells.
  always_comb
  begin
    s_nxt.flag = cell_nxt;
  end

  // Flags clear on every reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign flags = s_r.flag;

  // A flag raised by an event stays until a write clears it.
  AST_FLAG_STICKY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_r.flag[0] && !wr_en) |=> s_r.flag[0])
    else $error("Flag dropped without a write.");
  AST_EVENT_WINS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (unit_event[N-1] && wr_en) |=> s_r.flag[N-1])
    else $error("Event lost against a write.");
endmodule

// File: irq_context_unit.sv
// Purpose: Interrupt entry context save/restore and unit flag register.
// Assumes: Core inputs and unit events come from logic on pclk.
// Notes: The rules that this block carries are listed below.
// Contract
// - Push the return PC onto the call stack before vectoring.
// - On entry copy accumulator, bank, pointers and PC high latch.
// - Status is shadowed too, except watchdog-expiry and sleep bits.
// - On return reload every shadowed core register from its shadow.
// - Core writes during the service routine are lost at return.
// - Software writes to a shadow change what is restored.
// - Shadows sit in data bank 31, readable and writable.
// - Flag bits 4..0 belong to units five down to one.
// - A unit event sets its flag; it stays until software clears it.
// - Flags set regardless of unit enables and global enable.
// - Vector only when flag, its enable and global enable are set.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
module irq_context_unit #(
  parameter int N = ctx_pkg::UNITS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctx_pkg::ADDR_W-1:0] paddr,
  input wire logic [ctx_pkg::DATA_W-1:0] pwdata,
  output logic [ctx_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core sequencer: entry and return strobes with live registers.
  input wire logic irq_take,
  input wire logic irq_return,
  input wire logic [ctx_pkg::PC_W-1:0] ret_pc,
  input wire logic [7:0] core_acc,
  input wire logic [7:0] core_status,
  input wire logic [ctx_pkg::BSEL_W-1:0] bank_select_reg,
  input wire logic [ctx_pkg::PTR_W-1:0] indirect_ptr0,
  input wire logic [ctx_pkg::PTR_W-1:0] indirect_ptr1,
  input wire logic [ctx_pkg::PCH_W-1:0] pc_high_latch,
  // Stack push and vector request to the core.
  output logic stack_push,
  output logic [ctx_pkg::PC_W-1:0] stack_push_pc,
  output logic vector_go,
  output logic vector_req,
  // Restore strobe and values to the core.
  output logic restore,
  output logic [7:0] restore_acc,
  output logic [7:0] restore_status,
  output logic [ctx_pkg::BSEL_W-1:0] restore_bank,
  output logic [ctx_pkg::PTR_W-1:0] restore_ptr0,
  output logic [ctx_pkg::PTR_W-1:0] restore_ptr1,
  output logic [ctx_pkg::PCH_W-1:0] restore_pch,
  // Capture/compare/PWM unit events.
  input wire logic [N-1:0] unit_event,
  // Interrupt line.
  output logic irq
);
  typedef struct packed {
    ctx_pkg::seq_t st;
    logic [7:0] acc;
    logic [7:0] stat;
    logic [ctx_pkg::BSEL_W-1:0] bsel;
    logic [ctx_pkg::PTR_W-1:0] ptr0;
    logic [ctx_pkg::PTR_W-1:0] ptr1;
    logic [ctx_pkg::PCH_W-1:0] pch;
    logic push;
    logic [ctx_pkg::PC_W-1:0] push_pc;
    logic go;
    logic rest;
    logic [7:0] rest_stat;
    logic [N-1:0] unit_en;
    logic glb_en;
    logic vreq;
    logic [ctx_pkg::EVT_W-1:0] sts;
    logic [ctx_pkg::EVT_W-1:0] mask;
    logic [ctx_pkg::DATA_W-1:0] rdata;
    logic rdy;
    logic err;
    logic irq;
  } state_t;

  state_t s_r, s_nxt;
  logic [N-1:0] flags;
  logic setup;
  logic wr;
  logic flag_wr;
  logic hit;
  logic [ctx_pkg::DATA_W-1:0] rd_val;
  logic [ctx_pkg::EVT_W-1:0] ev;

  // Flag register; its write shares the APB completion edge.
  ccp_flag_reg #(.N(N)) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .unit_event(unit_event),
    .wr_en(flag_wr),
    .wr_data(pwdata[N-1:0]),
    .flags(flags)
  );

  // Setup phase samples read data; writes land at the completing edge.
  assign setup = psel && !penable;
  assign wr = psel && penable && s_r.rdy && pwrite && !s_r.err;
  assign flag_wr = wr && (paddr == ctx_pkg::OFS_FLAGS);

  // Read mux and address decode for the setup cycle.
  always_comb
  begin
    rd_val = '0;
    hit = 1'b1;
    unique case (paddr)
      ctx_pkg::OFS_FLAGS:
        rd_val[N-1:0] = flags;
      ctx_pkg::OFS_ENABLE:
      begin
        rd_val[N-1:0] = s_r.unit_en;
        rd_val[ctx_pkg::EN_GLOBAL_BIT] = s_r.glb_en;
      end
      ctx_pkg::OFS_STATE:
        rd_val[1:0] = s_r.st;
      ctx_pkg::OFS_IRQ_STS:
        rd_val[ctx_pkg::EVT_W-1:0] = s_r.sts;
      ctx_pkg::OFS_IRQ_MASK:
        rd_val[ctx_pkg::EVT_W-1:0] = s_r.mask;
      ctx_pkg::OFS_SH_ACC:
        rd_val[7:0] = s_r.acc;
      ctx_pkg::OFS_SH_STATUS:
        rd_val[7:0] = s_r.stat;
      ctx_pkg::OFS_SH_BANK:
        rd_val[ctx_pkg::BSEL_W-1:0] = s_r.bsel;
      ctx_pkg::OFS_SH_PTR0:
        rd_val[ctx_pkg::PTR_W-1:0] = s_r.ptr0;
      ctx_pkg::OFS_SH_PTR1:
        rd_val[ctx_pkg::PTR_W-1:0] = s_r.ptr1;
      ctx_pkg::OFS_SH_PCH:
        rd_val[ctx_pkg::PCH_W-1:0] = s_r.pch;
      default:
        hit = 1'b0;
    endcase
  end

  // Next state of the whole unit.
  always_comb
  begin
    s_nxt = s_r;
    ev = '0;
    s_nxt.push = 1'b0;
    s_nxt.go = 1'b0;
    s_nxt.rest = 1'b0;
    // APB answer: no wait state, pready for one cycle in the access phase.
    s_nxt.rdy = setup && !s_r.rdy;
    s_nxt.err = setup && !s_r.rdy && !hit;
    if (setup && !s_r.rdy)
      s_nxt.rdata = hit && !pwrite ? rd_val : '0;
    // Software writes to shadows change what a return reloads.
    if (wr)
    begin
      unique case (paddr)
        ctx_pkg::OFS_ENABLE:
        begin
          s_nxt.unit_en = pwdata[N-1:0];
          s_nxt.glb_en = pwdata[ctx_pkg::EN_GLOBAL_BIT];
        end
        ctx_pkg::OFS_IRQ_MASK:
          s_nxt.mask = pwdata[ctx_pkg::EVT_W-1:0];
        ctx_pkg::OFS_SH_ACC:
          s_nxt.acc = pwdata[7:0];
        ctx_pkg::OFS_SH_STATUS:
          s_nxt.stat = pwdata[7:0] & ~ctx_pkg::STATUS_EXCL;
        ctx_pkg::OFS_SH_BANK:
          s_nxt.bsel = pwdata[ctx_pkg::BSEL_W-1:0];
        ctx_pkg::OFS_SH_PTR0:
          s_nxt.ptr0 = pwdata[ctx_pkg::PTR_W-1:0];
        ctx_pkg::OFS_SH_PTR1:
          s_nxt.ptr1 = pwdata[ctx_pkg::PTR_W-1:0];
        ctx_pkg::OFS_SH_PCH:
          s_nxt.pch = pwdata[ctx_pkg::PCH_W-1:0];
        default:
          s_nxt.unit_en = s_r.unit_en;
      endcase
    end
    // Entry: push the PC, capture the context, vector a cycle later.
    unique case (s_r.st)
      ctx_pkg::ST_IDLE:
        if (irq_take)
          s_nxt.st = ctx_pkg::ST_VECTOR;
      ctx_pkg::ST_VECTOR:
      begin
        s_nxt.go = 1'b1;
        s_nxt.st = ctx_pkg::ST_ISR;
      end
      ctx_pkg::ST_ISR:
        if (irq_return)
        begin
          s_nxt.rest = 1'b1;
          s_nxt.st = ctx_pkg::ST_IDLE;
          ev[ctx_pkg::EV_RETURN] = 1'b1;
        end
        else if (irq_take)
        begin
          s_nxt.st = ctx_pkg::ST_VECTOR;
          ev[ctx_pkg::EV_OVERWRITE] = 1'b1;
        end
      default:
        s_nxt.st = ctx_pkg::ST_IDLE;
    endcase
    // Capture beats a same-cycle software write: the entry owns the copy.
    if (irq_take && s_r.st != ctx_pkg::ST_VECTOR)
    begin
      s_nxt.push = 1'b1;
      s_nxt.push_pc = ret_pc;
      s_nxt.acc = core_acc;
      s_nxt.bsel = bank_select_reg;
      s_nxt.ptr0 = indirect_ptr0;
      s_nxt.ptr1 = indirect_ptr1;
      s_nxt.pch = pc_high_latch;
      s_nxt.stat = core_status & ~ctx_pkg::STATUS_EXCL;
      ev[ctx_pkg::EV_ENTRY] = 1'b1;
    end
    // Live watchdog and sleep bits pass through the restore untouched.
    if (s_r.st == ctx_pkg::ST_ISR && irq_return)
      s_nxt.rest_stat = (s_r.stat & ~ctx_pkg::STATUS_EXCL)
        | (core_status & ctx_pkg::STATUS_EXCL);
    // Sticky status: write one to clear, a new event wins.
    if (wr && paddr == ctx_pkg::OFS_IRQ_STS)
      s_nxt.sts = s_r.sts & ~pwdata[ctx_pkg::EVT_W-1:0];
    s_nxt.sts = s_nxt.sts | ev;
    s_nxt.irq = |(s_nxt.sts & s_nxt.mask);
    // Vector request needs flag, enable and global enable together.
    s_nxt.vreq = s_nxt.glb_en && |(flags & s_nxt.unit_en);
  end

  // All unit state but the flag word, which sits in u_flags, in one register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.st <= ctx_pkg::ST_IDLE;
      s_r.mask <= ctx_pkg::MASK_RST;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs come straight from the state register.
  assign prdata = s_r.rdata;
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign stack_push = s_r.push;
  assign stack_push_pc = s_r.push_pc;
  assign vector_go = s_r.go;
  assign vector_req = s_r.vreq;
  assign restore = s_r.rest;
  assign restore_acc = s_r.acc;
  assign restore_status = s_r.rest_stat;
  assign restore_bank = s_r.bsel;
  assign restore_ptr0 = s_r.ptr0;
  assign restore_ptr1 = s_r.ptr1;
  assign restore_pch = s_r.pch;
  assign irq = s_r.irq;

  // Every check below runs on pclk and sleeps while reset is low.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PUSH_BEFORE_VECTOR: assert property (
    (irq_take && s_r.st == ctx_pkg::ST_IDLE) |=> stack_push ##1 vector_go)
    else $error("Vector without a prior stack push.");
  AST_PUSH_PC: assert property (
    (irq_take && s_r.st == ctx_pkg::ST_IDLE)
      |=> stack_push_pc == $past(ret_pc))
    else $error("Pushed PC differs from return PC.");
  AST_SAVE_CTX: assert property (
    (irq_take && s_r.st == ctx_pkg::ST_IDLE) |=>
      (restore_acc == $past(core_acc) && restore_ptr0 == $past(indirect_ptr0)
       && restore_pch == $past(pc_high_latch)))
    else $error("Context not captured on entry.");
  AST_STATUS_EXCL: assert property (
    restore |-> ((restore_status & ctx_pkg::STATUS_EXCL)
      == ($past(core_status) & ctx_pkg::STATUS_EXCL)))
    else $error("Excluded status bits were restored.");
  AST_RESTORE_ONCE: assert property (
    (s_r.st == ctx_pkg::ST_ISR && irq_return) |=> restore ##1 !restore)
    else $error("Restore strobe missing or too long.");
  AST_CORE_WRITE_LOST: assert property (
    (s_r.st == ctx_pkg::ST_ISR && !irq_take && !wr) |=>
      $stable(restore_acc) && $stable(restore_bank))
    else $error("Shadow changed without entry or software write.");
  AST_SHADOW_WRITE: assert property (
    (wr && paddr == ctx_pkg::OFS_SH_ACC && !irq_take)
      |=> restore_acc == $past(pwdata[7:0]))
    else $error("Shadow write not kept for restore.");
  AST_UPPER_ZERO: assert property (
    (pready && $past(paddr) == ctx_pkg::OFS_FLAGS) |-> prdata[7:N] == '0)
    else $error("Unimplemented flag bits read non-zero.");
  // Judged against the registered enables and the flag word a cycle back.
  AST_VECTOR_GATE: assert property (
    vector_req |-> (s_r.glb_en && |($past(flags) & s_r.unit_en)))
    else $error("Vector request without enables.");
  AST_OVERWRITE: assert property (
    (irq_take && s_r.st == ctx_pkg::ST_ISR)
      |=> restore_acc == $past(core_acc))
    else $error("Re-entry did not overwrite shadow.");
  AST_IRQ_LEVEL: assert property (
    irq == |($past(s_nxt.sts & s_nxt.mask)))
    else $error("Interrupt line disagrees with status.");

  // Refused requests must leave the core strobes quiet.
  AST_TAKE_REFUSED: assert property (
    (irq_take && s_r.st == ctx_pkg::ST_VECTOR) |=> !stack_push)
    else $error("Entry accepted during the vector cycle.");
  AST_RETURN_REFUSED: assert property (
    (irq_return && s_r.st != ctx_pkg::ST_ISR) |=> !restore)
    else $error("Restore outside the service routine.");

  // The flag word read back is the one latched at the setup edge.
  AST_FLAG_READ: assert property (
    (pready && !pslverr && $past(paddr) == ctx_pkg::OFS_FLAGS
      && !$past(pwrite)) |-> prdata[N-1:0] == $past(flags))
    else $error("Flag word read back differs from the flags.");
  // A longer ready would let one request complete twice.
  AST_PREADY_PULSE: assert property (
    pready |=> !pready)
    else $error("Ready held longer than one cycle.");

  COV_ENTRY_RETURN: cover property (
    stack_push ##[1:20] restore);
  COV_NESTED: cover property (
    irq_take && s_r.st == ctx_pkg::ST_ISR);
  COV_SHADOW_EDIT: cover property (
    (wr && paddr == ctx_pkg::OFS_SH_ACC) ##[1:20] restore);
  COV_VECTOR_REQ: cover property (vector_req);
  COV_FLAG_SET: cover property (
    |unit_event ##1 (flags != '0));
endmodule

// File: core_model.sv
// Purpose: Core sequencer and capture/compare/PWM unit model.
// Assumes: Strobes change by non-blocking assignment after pclk rises.
// Notes: Live registers reload from the restore values like a real core.
`timescale 1ns/100ps
module core_model (
  // Clock.
  input wire logic pclk,
  // Restore strobe and values from the context unit.
  input wire logic restore,
  input wire logic [7:0] restore_acc,
  input wire logic [7:0] restore_status,
  input wire logic [5:0] restore_bank,
  input wire logic [15:0] restore_ptr0,
  input wire logic [15:0] restore_ptr1,
  input wire logic [6:0] restore_pch,
  // Strobes, live core registers and unit events.
  output logic irq_take,
  output logic irq_return,
  output logic [14:0] ret_pc,
  output logic [7:0] core_acc,
  output logic [7:0] core_status,
  output logic [5:0] bank_select_reg,
  output logic [15:0] indirect_ptr0,
  output logic [15:0] indirect_ptr1,
  output logic [6:0] pc_high_latch,
  output logic [4:0] unit_event
);
  // Start quiet so the unit sees no stray strobe at reset release.
  initial
  begin
    {irq_take, irq_return, unit_event} = '0;
    {ret_pc, core_acc, core_status, bank_select_reg} = '0;
    {indirect_ptr0, indirect_ptr1, pc_high_latch} = '0;
  end

  // The core takes back every saved register on the restore strobe.
  always @(posedge pclk)
    if (restore === 1'b1)
    begin
      core_acc <= restore_acc;
      core_status <= restore_status;
      bank_select_reg <= restore_bank;
      indirect_ptr0 <= restore_ptr0;
      indirect_ptr1 <= restore_ptr1;
      pc_high_latch <= restore_pch;
    end

  // One-cycle strobes; an event pulse is already qualified by its mode.
  task automatic strobe(input logic t, input logic r, input logic [4:0] m);
    @(posedge pclk);
    irq_take <= t;
    irq_return <= r;
    unit_event <= m;
    @(posedge pclk);
    {irq_take, irq_return, unit_event} <= '0;
  endtask
endmodule

// File: irq_context_save_and_ccp_flags_test.sv
// Purpose: Self-checking bench for the context unit and flag register.
// Assumes: APB answers the cycle after setup, as the hand-over states.
// Notes: Level outputs lag their cause by one cycle, so checks wait two.
`timescale 1ns/100ps
module irq_context_save_and_ccp_flags_test;
  // Clock, reset and APB master.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  // Design and model signals.
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, stack_push, vector_go, vector_req, restore;
  logic irq, irq_take, irq_return;
  logic [14:0] ret_pc, stack_push_pc;
  logic [7:0] core_acc, core_status, restore_acc, restore_status;
  logic [5:0] bank_select_reg, restore_bank;
  logic [15:0] indirect_ptr0, indirect_ptr1, restore_ptr0, restore_ptr1;
  logic [6:0] pc_high_latch, restore_pch;
  logic [4:0] unit_event;
  int n_fail = 0;
  int n_tests = 0;

  irq_context_unit dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_take(irq_take),
    .irq_return(irq_return), .ret_pc(ret_pc), .core_acc(core_acc),
    .core_status(core_status), .bank_select_reg(bank_select_reg),
    .indirect_ptr0(indirect_ptr0), .indirect_ptr1(indirect_ptr1),
    .pc_high_latch(pc_high_latch), .stack_push(stack_push),
    .stack_push_pc(stack_push_pc), .vector_go(vector_go),
    .vector_req(vector_req), .restore(restore),
    .restore_acc(restore_acc), .restore_status(restore_status),
    .restore_bank(restore_bank), .restore_ptr0(restore_ptr0),
    .restore_ptr1(restore_ptr1), .restore_pch(restore_pch),
    .unit_event(unit_event), .irq(irq)
  );

  core_model core_u (
    .pclk(pclk), .restore(restore), .restore_acc(restore_acc),
    .restore_status(restore_status), .restore_bank(restore_bank),
    .restore_ptr0(restore_ptr0), .restore_ptr1(restore_ptr1),
    .restore_pch(restore_pch), .irq_take(irq_take),
    .irq_return(irq_return), .ret_pc(ret_pc), .core_acc(core_acc),
    .core_status(core_status), .bank_select_reg(bank_select_reg),
    .indirect_ptr0(indirect_ptr0), .indirect_ptr1(indirect_ptr1),
    .pc_high_latch(pc_high_latch), .unit_event(unit_event)
  );

  // Free-running 25 MHz clock.
  initial
    forever #20 pclk = ~pclk;

  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_fail++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  // Level outputs settle one cycle after their cause.
  task automatic wait2();
    repeat (2) @(negedge pclk);
  endtask

  task automatic t_flags();
    int u;
    @(negedge pclk);
    chk("irq", irq, 1'b0);
    rd_chk("flags", ctx_pkg::OFS_FLAGS, 32'h0);
    for (u = 0; u < 5; u++)
    begin
      core_u.strobe(1'b0, 1'b0, 5'h01 << u);
      repeat (3) @(posedge pclk);
      rd_chk("flag", ctx_pkg::OFS_FLAGS, 32'h1 << u);
      apb(1'b1, ctx_pkg::OFS_FLAGS, 32'h0);
    end
    rd_chk("flags", ctx_pkg::OFS_FLAGS, 32'h0);
    apb(1'b1, ctx_pkg::OFS_FLAGS, 32'hFF);
    rd_chk("flags", ctx_pkg::OFS_FLAGS, 32'h1F);
    rd_chk("unmapped", 12'h100, 32'h0);
    chk("pslverr", err, 1'b1);
  endtask

  // Enter, edit shadow and live copies, return.
  task automatic t_entry();
    @(posedge pclk);
    {core_u.core_acc, core_u.core_status} <= 16'hA5FF;
    {core_u.bank_select_reg, core_u.pc_high_latch} <= 13'h15D5;
    {core_u.indirect_ptr0, core_u.indirect_ptr1} <= 32'h1234BEEF;
    core_u.ret_pc <= 15'h1ABC;
    core_u.strobe(1'b1, 1'b0, 5'h00);
    @(negedge pclk);
    chk("push", stack_push, 1'b1);
    chk("push_pc", stack_push_pc, 15'h1ABC);
    chk("vec_early", vector_go, 1'b0);
    @(negedge pclk);
    chk("vector_go", vector_go, 1'b1);
    rd_chk("sh_acc", ctx_pkg::OFS_SH_ACC, 32'hA5);
    rd_chk("sh_st", ctx_pkg::OFS_SH_STATUS, 32'hE7);
    rd_chk("sh_bank", ctx_pkg::OFS_SH_BANK, 32'h2B);
    rd_chk("sh_p0", ctx_pkg::OFS_SH_PTR0, 32'h1234);
    rd_chk("sh_p1", ctx_pkg::OFS_SH_PTR1, 32'hBEEF);
    rd_chk("sh_pch", ctx_pkg::OFS_SH_PCH, 32'h55);
    {core_u.core_acc, core_u.core_status} <= 16'h0008;
    core_u.bank_select_reg <= 6'h01;
    {core_u.indirect_ptr0, core_u.pc_high_latch} <= 23'h0;
    apb(1'b1, ctx_pkg::OFS_SH_ACC, 32'h3C);
    rd_chk("sh_acc_w", ctx_pkg::OFS_SH_ACC, 32'h3C);
    core_u.strobe(1'b0, 1'b1, 5'h00);
    @(negedge pclk);
    chk("restore", restore, 1'b1);
    chk("rst_acc", restore_acc, 8'h3C);
    chk("rst_st", restore_status, 8'hEF);
    @(negedge pclk);
    chk("live_acc", core_acc, 8'h3C);
    chk("live_bank", bank_select_reg, 6'h2B);
    chk("live_p1", indirect_ptr1, 16'hBEEF);
    chk("live_p0", indirect_ptr0, 16'h1234);
    chk("live_pch", pc_high_latch, 7'h55);
    chk("live_st", core_status, 8'hEF);
  endtask

  // Second entry inside the routine overwrites the one saved copy.
  task automatic t_nest();
    apb(1'b1, ctx_pkg::OFS_IRQ_STS, 32'h7);
    apb(1'b1, ctx_pkg::OFS_IRQ_MASK, 32'h4);
    core_u.strobe(1'b1, 1'b0, 5'h00);
    rd_chk("state", ctx_pkg::OFS_STATE, 32'h2);
    core_u.core_acc <= 8'h77;
    core_u.strobe(1'b1, 1'b0, 5'h00);
    rd_chk("sh_acc2", ctx_pkg::OFS_SH_ACC, 32'h77);
    rd_chk("sts", ctx_pkg::OFS_IRQ_STS, 32'h5);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, ctx_pkg::OFS_IRQ_MASK, 32'h0);
    wait2();
    chk("irq_masked", irq, 1'b0);
    apb(1'b1, ctx_pkg::OFS_IRQ_MASK, 32'h4);
    wait2();
    chk("irq_unmask", irq, 1'b1);
    apb(1'b1, ctx_pkg::OFS_IRQ_STS, 32'h4);
    wait2();
    chk("irq_clear", irq, 1'b0);
    core_u.strobe(1'b0, 1'b1, 5'h00);
  endtask

  // Vector only with flag, unit enable and global enable together.
  task automatic t_vector();
    apb(1'b1, ctx_pkg::OFS_FLAGS, 32'h0);
    core_u.strobe(1'b0, 1'b0, 5'h04);
    apb(1'b1, ctx_pkg::OFS_ENABLE, 32'h04);
    wait2();
    chk("vreq_nog", vector_req, 1'b0);
    apb(1'b1, ctx_pkg::OFS_ENABLE, 32'h84);
    wait2();
    chk("vreq_on", vector_req, 1'b1);
    apb(1'b1, ctx_pkg::OFS_ENABLE, 32'h80);
    wait2();
    chk("vreq_noen", vector_req, 1'b0);
  endtask

  // Reset, then the scenarios in order.
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_flags();
    t_entry();
    t_nest();
    t_vector();
    tally_and_finish();
  end
endmodule
